// *** cpu_exec_pkg.sv ***
// constants, opcodes and states of the instruction execution block
//
// Behaviour
// - bit test addresses file register 0..127 and picks one bit by 3-bit index.
// - tested bit zero: next instruction runs normally, no flag changes.
// - tested bit one: next instruction is discarded, a no-operation runs, two cycles.
// - watchdog clear loads counter with zero, has no operands, keeps zero flag.
// - watchdog clear also resets the watchdog prescaler to zero.
// - watchdog clear sets timeout and power-down flags (both active low) to one.
// - call pushes program counter plus one onto the return stack top.
// - call loads its 11-bit operand into program counter bits 10..0.
// - call fills program counter bits 12..11 from high latch bits 4..3.
// - call takes two instruction cycles and changes no status flag.
// - complement inverts register into accumulator or register by destination bit; zero flag.
// - clear register writes zero into file register 0..127 and sets zero flag.
// - clear accumulator takes no operands, zeroes accumulator, sets zero flag.
// - decrement subtracts one into accumulator or register by destination bit; zero flag.
// - program counter change or true test takes two cycles, second is no-operation.
package cpu_exec_pkg;
  // clock and instruction cycle (one instruction cycle = CYC_DIV clocks)
  localparam int unsigned CLK_HZ  = 40_000_000;
  localparam int unsigned CYC_DIV = 4;
  // bus map, byte addresses
  localparam logic [11:0] OFF_INSTR  = 12'h000;
  localparam logic [11:0] OFF_ACC    = 12'h004;
  localparam logic [11:0] OFF_PC     = 12'h008;
  localparam logic [11:0] OFF_PC_HIGH_LATCH = 12'h00C;
  localparam logic [11:0] OFF_STATUS = 12'h010;
  localparam logic [11:0] OFF_WDOG   = 12'h014;
  localparam logic [11:0] OFF_STACK  = 12'h018;
  localparam logic [2:0]  FILE_PAGE  = 3'h1; // 0x200..0x3FC file registers
  // instruction word fields
  localparam int unsigned OP_LSB = 12;
  localparam int unsigned B_LSB  = 8;
  localparam int unsigned D_BIT  = 7;
  // status register bits
  localparam int unsigned ST_ZERO = 0;
  localparam int unsigned ST_TO_N = 1;
  localparam int unsigned ST_PD_N = 2;
  localparam int unsigned ST_BUSY = 3;
  // reset values and watchdog limits
  localparam logic [12:0] PC_RST     = 13'h0000;
  localparam logic [7:0]  PRESC_MAX  = 8'hFF;
  localparam logic [7:0]  WDOG_MAX   = 8'hFF;
  localparam int unsigned STACK_DEPTH = 8;

  typedef enum logic [3:0] {
    OP_NOP   = 4'h0,
    OP_BTS   = 4'h1,
    OP_WDCLR = 4'h2,
    OP_CALL  = 4'h3,
    OP_COMPLEMENT_FILE_INSTR  = 4'h4,
    OP_CLEAR_FILE_INSTR  = 4'h5,
    OP_CLEAR_ACCUMULATOR_INSTR  = 4'h6,
    OP_DECREMENT_FILE_INSTR  = 4'h7
  } instr_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_NOPC = 2'b10
  } exec_state_t;
endpackage

// *** cpu_instr_exec_subset.sv ***
// instruction execution subset with classic wishbone register slave
//
// The register offsets and the Wishbone slave port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module cpu_instr_exec_subset
  import cpu_exec_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             busy
);

  // merge the two low byte lanes of a write into a 16-bit register
  function automatic logic [15:0] laneMerge(input logic [15:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0]  sel);
    laneMerge = {sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
  endfunction

  // true for an address in the file register page
  function automatic logic isFileAdr(input logic [11:0] a);
    isFileAdr = (a[11:9] == FILE_PAGE);
  endfunction

  logic        ackQ;
  logic [31:0] rdQ;
  logic [1:0]  divQ;
  exec_state_t stateQ;
  exec_state_t stateD;
  logic [15:0] instrQ;
  logic [7:0]  accQ;
  logic [12:0] pcQ;
  logic [7:0]  pclathQ;
  logic        zeroQ;
  logic        toNQ;
  logic        pdNQ;
  logic [7:0]  wdogQ;
  logic [7:0]  prescQ;
  logic [2:0]  spQ;
  logic [12:0] stackQ [STACK_DEPTH];
  logic [7:0]  fileMem [128];

  // instruction cycle enable from the clock divider
  wire tick = (divQ == 2'(CYC_DIV - 1));

  // bus request decode
  wire busReq   = wb_cyc_i & wb_stb_i & ~ackQ;
  wire wrReq    = busReq & wb_we_i;
  wire wrInstr  = wrReq & (wb_adr_i == OFF_INSTR) & (stateQ == ST_IDLE);
  wire wrAcc    = wrReq & (wb_adr_i == OFF_ACC);
  wire wrPc     = wrReq & (wb_adr_i == OFF_PC);
  wire wrPclath = wrReq & (wb_adr_i == OFF_PC_HIGH_LATCH);
  wire wrStatus = wrReq & (wb_adr_i == OFF_STATUS);
  wire wrFile   = wrReq & isFileAdr(wb_adr_i);
  wire [6:0] busFile = wb_adr_i[8:2];

  // instruction fields
  wire [3:0]  op    = instrQ[15:OP_LSB];
  wire [6:0]  fAdr  = instrQ[6:0];
  wire [2:0]  bIdx  = instrQ[B_LSB+2:B_LSB];
  wire        dest  = instrQ[D_BIT];
  wire [10:0] kAdr  = instrQ[10:0];
  wire [7:0]  fVal  = fileMem[fAdr];
  wire        bitSet = fVal[bIdx];

  wire isBts   = (op == OP_BTS);
  wire isWdclr = (op == OP_WDCLR);
  wire isCall  = (op == OP_CALL);
  wire isComf  = (op == OP_COMPLEMENT_FILE_INSTR);
  wire isClrf  = (op == OP_CLEAR_FILE_INSTR);
  wire isClrw  = (op == OP_CLEAR_ACCUMULATOR_INSTR);
  wire isDecf  = (op == OP_DECREMENT_FILE_INSTR);
  wire isArith = isComf | isDecf;

  // execution strobes
  wire execNow    = tick & (stateQ == ST_EXEC);
  wire takeSecond = isCall | (isBts & bitSet);
  wire [7:0] resVal = isComf ? ~fVal : fVal - 8'h01;
  wire fileWrEx   = execNow & ((isArith & dest) | isClrf);
  wire [7:0] fileWrVal = isClrf ? 8'h00 : resVal;
  wire accWrEx    = execNow & ((isArith & ~dest) | isClrw);
  wire [7:0] accWrVal = isClrw ? 8'h00 : resVal;
  wire zeroWrEx   = execNow & (isArith | isClrf | isClrw);
  wire zeroVal    = (isClrf | isClrw) ? 1'b1 : (resVal == 8'h00);

  // program counter next value
  wire [12:0] pcCall = {pclathQ[4:3], kAdr};
  wire [12:0] pcInc  = pcQ + 13'h0001;
  wire [12:0] pcSkip = pcQ + 13'h0002;
  wire [12:0] pcExec = isCall ? pcCall : ((isBts & bitSet) ? pcSkip : pcInc);

  // watchdog count events
  wire prescWrap = tick & (prescQ == PRESC_MAX);
  wire wdogWrap  = prescWrap & (wdogQ == WDOG_MAX);
  wire wdClrEx   = execNow & isWdclr;

  // read data selection
  wire [31:0] rdSel =
    (wb_adr_i == OFF_INSTR)  ? {15'h0000, busy, instrQ} :
    (wb_adr_i == OFF_ACC)    ? {24'h000000, accQ} :
    (wb_adr_i == OFF_PC)     ? {19'h00000, pcQ} :
    (wb_adr_i == OFF_PC_HIGH_LATCH) ? {24'h000000, pclathQ} :
    (wb_adr_i == OFF_STATUS) ? {28'h0000000, busy, pdNQ, toNQ, zeroQ} :
    (wb_adr_i == OFF_WDOG)   ? {16'h0000, prescQ, wdogQ} :
    (wb_adr_i == OFF_STACK)  ? {19'h00000, stackQ[spQ]} :
    isFileAdr(wb_adr_i)      ? {24'h000000, fileMem[busFile]} :
    32'h00000000;

  assign busy     = (stateQ != ST_IDLE);
  assign wb_ack_o = ackQ;
  assign wb_dat_o = rdQ;

  // bus acknowledge one cycle after the request, read data with it
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ackQ <= 1'b0;
      rdQ  <= 32'h00000000;
    end else begin
      ackQ <= busReq;
      rdQ  <= busReq ? rdSel : rdQ;
    end
  end

  // instruction cycle divider
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) divQ <= 2'h0;
    else divQ <= tick ? 2'h0 : divQ + 2'h1;
  end

  // sequencer: idle, execute cycle, optional no-operation cycle
  always_comb begin
    stateD = stateQ;
    case (stateQ)
      ST_IDLE: if (wrInstr) stateD = ST_EXEC;
      ST_EXEC: if (tick) stateD = takeSecond ? ST_NOPC : ST_IDLE;
      ST_NOPC: if (tick) stateD = ST_IDLE;
      default: stateD = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) stateQ <= ST_IDLE;
    else stateQ <= stateD;
  end

  // instruction word latch, taken only while idle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) instrQ <= 16'h0000;
    else if (wrInstr) instrQ <= laneMerge(instrQ, wb_dat_i, wb_sel_i);
  end

  // accumulator; execution wins over a bus write
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) accQ <= 8'h00;
    else if (accWrEx) accQ <= accWrVal;
    else if (wrAcc && wb_sel_i[0]) accQ <= wb_dat_i[7:0];
  end

  // program counter and its high latch
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pcQ     <= PC_RST;
      pclathQ <= 8'h00;
    end else begin
      if (execNow) pcQ <= pcExec;
      else if (wrPc) pcQ <= 13'(laneMerge({3'h0, pcQ}, wb_dat_i, wb_sel_i));
      if (wrPclath && wb_sel_i[0]) pclathQ <= wb_dat_i[7:0];
    end
  end

  // zero flag; watchdog clear, call and bit test leave it alone
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) zeroQ <= 1'b0;
    else if (zeroWrEx) zeroQ <= zeroVal;
    else if (wrStatus && wb_sel_i[0]) zeroQ <= wb_dat_i[ST_ZERO];
  end

  // watchdog prescaler, counter and active-low status flags
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prescQ <= 8'h00;
      wdogQ  <= 8'h00;
      toNQ   <= 1'b1;
      pdNQ   <= 1'b1;
    end else if (wdClrEx) begin
      prescQ <= 8'h00;
      wdogQ  <= 8'h00;
      toNQ   <= 1'b1;
      pdNQ   <= 1'b1;
    end else if (tick) begin
      prescQ <= prescWrap ? 8'h00 : prescQ + 8'h01;
      wdogQ  <= prescWrap ? wdogQ + 8'h01 : wdogQ;
      toNQ   <= wdogWrap ? 1'b0 : toNQ;
    end
  end

  // return stack pointer; a push moves to the next entry
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) spQ <= 3'h0;
    else if (execNow && isCall) spQ <= spQ + 3'h1;
  end

  // return stack entries, each written when the pointer lands on it
  for (genvar i = 0; i < STACK_DEPTH; i++) begin : gStack
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) stackQ[i] <= 13'h0000;
      else if (execNow && isCall && (spQ + 3'h1 == 3'(i))) stackQ[i] <= pcInc;
    end
  end

  // file registers; execution wins over a bus write
  always_ff @(posedge sys_clk) begin
    if (fileWrEx) fileMem[fAdr] <= fileWrVal;
    else if (wrFile && wb_sel_i[0]) fileMem[busFile] <= wb_dat_i[7:0];
  end

  // checks on execution results
  wdog_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
    wdClrEx |=> (wdogQ == 8'h00) && (prescQ == 8'h00) && $stable(zeroQ))
    else $error("watchdog clear left counter, prescaler or zero flag wrong");

  wdog_flags_a: assert property (@(posedge sys_clk) disable iff (rst)
    wdClrEx |=> toNQ && pdNQ && (pcQ == $past(pcInc)))
    else $error("watchdog clear did not set status flags");

  call_push_a: assert property (@(posedge sys_clk) disable iff (rst)
    (execNow && isCall) |=> (stackQ[spQ] == $past(pcInc)) && (spQ == $past(spQ) + 3'h1))
    else $error("call pushed wrong return address");

  call_target_a: assert property (@(posedge sys_clk) disable iff (rst)
    (execNow && isCall) |=> pcQ == {$past(pclathQ[4:3]), $past(kAdr)})
    else $error("call loaded wrong program counter");

  call_twocycle_a: assert property (@(posedge sys_clk) disable iff (rst)
    (execNow && isCall) |=> (stateQ == ST_NOPC) [*4] ##1 (stateQ == ST_IDLE))
    else $error("call did not take two instruction cycles");

  skip_taken_a: assert property (@(posedge sys_clk) disable iff (rst)
    (execNow && isBts && bitSet) |=> (stateQ == ST_NOPC) && (pcQ == $past(pcSkip)))
    else $error("set bit test did not skip");

  skip_not_a: assert property (@(posedge sys_clk) disable iff (rst)
    (execNow && isBts && !bitSet) |=> (stateQ == ST_IDLE) && $stable(zeroQ)
      && (pcQ == $past(pcInc)))
    else $error("clear bit test did not fall through");

  clear_file_instr_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
    (execNow && isClrf) |=> zeroQ && (fileMem[$past(fAdr)] == 8'h00))
    else $error("clear register left register or zero flag wrong");

  clear_accumulator_instr_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
    (execNow && isClrw) |=> zeroQ && (accQ == 8'h00))
    else $error("clear accumulator left accumulator or zero flag wrong");

  arith_acc_a: assert property (@(posedge sys_clk) disable iff (rst)
    (execNow && isArith && !dest) |=> (accQ == $past(resVal))
      && (zeroQ == ($past(resVal) == 8'h00)))
    else $error("complement or decrement result wrong in accumulator");

  single_cycle_a: assert property (@(posedge sys_clk) disable iff (rst)
    (execNow && (isArith || isClrf || isClrw)) |=> (stateQ == ST_IDLE)
      && (pcQ == $past(pcInc)))
    else $error("single-cycle instruction did not finish in one cycle");

  // checks on the bus handshake and the sequencer
  bus_ack_a: assert property (@(posedge sys_clk) disable iff (rst)
    busReq |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus acknowledge was not a single cycle pulse");

  instr_refused_a: assert property (@(posedge sys_clk) disable iff (rst)
    (wrReq && (wb_adr_i == OFF_INSTR) && busy) |=> $stable(instrQ))
    else $error("instruction word changed while busy");

  busy_start_a: assert property (@(posedge sys_clk) disable iff (rst)
    (stateQ == ST_IDLE && wrInstr) |=> busy)
    else $error("busy did not rise after an instruction write");

  bit_sense_a: assert property (@(posedge sys_clk) disable iff (rst)
    (execNow && isBts) |=> ((stateQ == ST_NOPC) == $past(fVal[bIdx])))
    else $error("bit test looked at the wrong bit");

  skip_flags_a: assert property (@(posedge sys_clk) disable iff (rst)
    (execNow && isBts && bitSet) |=> $stable(zeroQ) && $stable(accQ))
    else $error("set bit test changed a flag or the accumulator");

  nopc_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    (stateQ == ST_NOPC && !tick && !wrReq) |=> $stable(pcQ) && $stable(accQ)
      && $stable(zeroQ))
    else $error("no-operation cycle changed state");

  nopc_end_a: assert property (@(posedge sys_clk) disable iff (rst)
    (stateQ == ST_NOPC && tick) |=> (stateQ == ST_IDLE))
    else $error("no-operation cycle lasted too long");

  call_flags_a: assert property (@(posedge sys_clk) disable iff (rst)
    (execNow && isCall) |=> $stable(zeroQ) && $stable(accQ))
    else $error("call changed a flag or the accumulator");

  wdog_single_a: assert property (@(posedge sys_clk) disable iff (rst)
    wdClrEx |=> (stateQ == ST_IDLE))
    else $error("watchdog clear did not finish in one cycle");

  complement_file_instr_file_a: assert property (@(posedge sys_clk) disable iff (rst)
    (execNow && isComf && dest) |=> (fileMem[$past(fAdr)] == ~$past(fVal))
      && (zeroQ == ($past(fVal) == 8'hFF)))
    else $error("complement result wrong in file register");

  complement_file_instr_acc_a: assert property (@(posedge sys_clk) disable iff (rst)
    (execNow && isComf && !dest) |=> (accQ == ~$past(fVal)))
    else $error("complement result wrong in accumulator");

  decrement_file_instr_file_a: assert property (@(posedge sys_clk) disable iff (rst)
    (execNow && isDecf && dest) |=> (fileMem[$past(fAdr)] == $past(fVal) - 8'h01))
    else $error("decrement result wrong in file register");

  // idle program counter only moves by a bus write
  pc_idle_a: assert property (@(posedge sys_clk) disable iff (rst)
    (stateQ == ST_IDLE && !wrPc) |=> $stable(pcQ))
    else $error("program counter moved while idle");

  presc_count_a: assert property (@(posedge sys_clk) disable iff (rst)
    (!wdClrEx && tick && (prescQ != PRESC_MAX)) |=> (prescQ == $past(prescQ) + 8'h01))
    else $error("watchdog prescaler did not count");

endmodule // cpu_instr_exec_subset
`default_nettype wire

// *** cpu_instr_exec_subset_test.sv ***
// self-checking bench for the instruction execution subset
`timescale 1ns/100ps
`default_nettype none
`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin badCount++; \
  $display("ERROR %0t: got %h expected %h", $time, (got), (exp)); end end
module cpu_instr_exec_subset_test;
  import cpu_exec_pkg::*;
  typedef struct packed {
    logic [11:0] wa;
    logic [15:0] wd;
    logic [11:0] ra;
    logic [15:0] ex;
  } row_t;
  logic        sys_clk;
  logic        rst;
  logic        wbCyc;
  logic        wbStb;
  logic        wbWe;
  logic [3:0]  wbSel;
  logic [11:0] wbAdr;
  logic [31:0] wbDatW;
  logic [31:0] wbDatR;
  logic        wbAck;
  logic        busy;
  logic [31:0] rd;
  int          badCount;
  int          comparisons;
  int          n;
  // bus write then read back: write address, write data, read address, expected read
  row_t rows [15] = '{
    '{12'h214, 16'h005A, 12'h214, 16'h005A},
    '{12'h000, 16'h4005, 12'h004, 16'h00A5},
    '{12'h100, 16'h0000, 12'h010, 16'h0006},
    '{12'h000, 16'h4085, 12'h214, 16'h00A5},
    '{12'h000, 16'h7005, 12'h004, 16'h00A4},
    '{12'h218, 16'h0001, 12'h218, 16'h0001},
    '{12'h000, 16'h7086, 12'h218, 16'h0000},
    '{12'h100, 16'h0000, 12'h010, 16'h0007},
    '{12'h010, 16'h0000, 12'h010, 16'h0006},
    '{12'h3FC, 16'h0033, 12'h3FC, 16'h0033},
    '{12'h000, 16'h507F, 12'h3FC, 16'h0000},
    '{12'h100, 16'h0000, 12'h010, 16'h0007},
    '{12'h010, 16'h0000, 12'h100, 16'h0000},
    '{12'h000, 16'h6000, 12'h004, 16'h0000},
    '{12'h100, 16'h0000, 12'h010, 16'h0007}
  };
  logic [11:0] rstAdr [5] = '{12'h004, 12'h008, 12'h00C, 12'h010, 12'h018};
  logic [15:0] rstVal [5] = '{16'h0000, 16'h0000, 16'h0000, 16'h0006, 16'h0000};

  cpu_instr_exec_subset cpu_instr_exec_subset_inst (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .wb_cyc_i (wbCyc),
    .wb_stb_i (wbStb),
    .wb_we_i  (wbWe),
    .wb_sel_i (wbSel),
    .wb_adr_i (wbAdr),
    .wb_dat_i (wbDatW),
    .wb_dat_o (wbDatR),
    .wb_ack_o (wbAck),
    .busy     (busy)
  );

  // 40 MHz clock
  always #12.5 sys_clk = ~sys_clk;

  // one classic wishbone cycle, held until ack is sampled high
  task automatic wbXfer(input logic we, input logic [11:0] adr, input logic [15:0] dat);
    @(posedge sys_clk);
    wbCyc  <= 1'b1;
    wbStb  <= 1'b1;
    wbWe   <= we;
    wbAdr  <= adr;
    wbDatW <= {16'h0000, dat};
    @(posedge sys_clk iff wbAck === 1'b1);
    rd = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe  <= 1'b0;
  endtask

  // count clocks until the instruction has finished
  task automatic waitIdle(output int cnt);
    cnt = 0;
    while (busy === 1'b1) begin
      cnt++;
      @(posedge sys_clk);
    end
  endtask

  task automatic exec(input logic [15:0] w, output int cnt);
    wbXfer(1'b1, OFF_INSTR, w);
    waitIdle(cnt);
  endtask

  task automatic expectRd(input logic [11:0] a, input logic [15:0] e);
    wbXfer(1'b0, a, 16'h0000);
    `CHECK(rd, {16'h0000, e})
  endtask

  task automatic completeRun();
    if (badCount == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge sys_clk);
    badCount++;
    completeRun();
  end

  // main sequence
  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbSel = 4'h3;
    wbAdr = 12'h000;
    wbDatW = 32'h0000_0000;
    badCount = 0;
    comparisons = 0;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 15; i++) begin
      wbXfer(1'b1, rows[i].wa, rows[i].wd);
      if (rows[i].wa == OFF_INSTR) begin
        waitIdle(n);
      end
      expectRd(rows[i].ra, rows[i].ex);
    end
    expectRd(OFF_PC, 16'h0006);
    // second reset in mid-run, then reset values
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      expectRd(rstAdr[i], rstVal[i]);
    end
    // call with high latch bits 4..3 = 01
    wbXfer(1'b1, OFF_PC_HIGH_LATCH, 16'h0008);
    exec(16'h6000, n);
    `CHECK(n inside {[1:4]}, 1'b1)
    expectRd(OFF_PC, 16'h0001);
    exec(16'h37FF, n);
    `CHECK(n inside {[5:8]}, 1'b1)
    expectRd(OFF_PC, 16'h0FFF);
    expectRd(OFF_STACK, 16'h0002);
    expectRd(OFF_STATUS, 16'h0007);
    // bit test on set and clear bits, file register 0x10
    wbXfer(1'b1, 12'h240, 16'h0080);
    exec(16'h1710, n);
    `CHECK(n inside {[5:8]}, 1'b1)
    expectRd(OFF_PC, 16'h1001);
    exec(16'h1610, n);
    `CHECK(n inside {[1:4]}, 1'b1)
    expectRd(OFF_PC, 16'h1002);
    expectRd(OFF_STATUS, 16'h0007);
    // a second instruction written while busy is ignored
    wbXfer(1'b1, OFF_INSTR, 16'h1710);
    wbXfer(1'b1, OFF_INSTR, 16'h0000);
    waitIdle(n);
    expectRd(OFF_PC, 16'h1004);
    // unused opcode acts as a no-operation
    exec(16'hF000, n);
    expectRd(OFF_PC, 16'h1005);
    // watchdog clear after the prescaler has run
    wbXfer(1'b1, OFF_STATUS, 16'h0000);
    repeat (40) @(posedge sys_clk);
    expectRd(OFF_STATUS, 16'h0006);
    wbXfer(1'b0, OFF_WDOG, 16'h0000);
    `CHECK(rd[15:8] != 8'h00, 1'b1)
    exec(16'h2000, n);
    `CHECK(n inside {[1:4]}, 1'b1)
    wbXfer(1'b0, OFF_WDOG, 16'h0000);
    `CHECK(rd[7:0], 8'h00)
    `CHECK(rd[15:8] < 8'h02, 1'b1)
    expectRd(OFF_STATUS, 16'h0006);
    expectRd(OFF_PC, 16'h1006);
    completeRun();
  end
endmodule // cpu_instr_exec_subset_test
`default_nettype wire
